//--- pdc_consts.vh
// Constants for the peripheral disable and configuration block
// Notes on behaviour
// - Each configuration word is 24 bits wide and only its low 16 bits hold configuration data.
// - Four configuration words (oscillator, watchdog, brown-out/power-on, code protect) sit at fixed program-space addresses.
// - Software reads the configuration words back through the table-read path into program space.
// - A set disable bit stops every clock to that peripheral, leaving it at minimum power.
// - While a peripheral is disabled, writes to its registers are dropped and reads are undefined.
// - A peripheral runs only when its disable bit is clear and it is implemented in this variant.
// - Every disable bit resets to zero, so implemented peripherals are enabled one instruction cycle after reset.
// - Setting a disable bit disables the peripheral one instruction cycle later.
// - Clearing a disable bit re-enables the peripheral one instruction cycle later with its settings kept.
// - Disable register one holds timers five to one in bits 15..11, codec bit 8, I2C bit 7, UARTs 6..5, SPIs 4..3, CANs 2..1, ADC bit 0.
// - Disable register two holds capture channels eight to one in bits 15..8 and compare eight to one in bits 7..0.
// - With debugging on, the lowest 80 bytes of data RAM and two pins are reserved for the debugger.
// - The debug link may use any one of four pin pairs chosen by configuration.
// - In the chosen pair one pin carries two-way debug data and the other the debug clock.
// - The primary pair shares the programming clock and data pins; the three alternates use separate pins.
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH
`define PDC_ADDR_DIS1 16'h0770
`define PDC_ADDR_DIS2 16'h0772
`define PDC_ADDR_CFG_OSC 24'hF80000
`define PDC_ADDR_CFG_WDT 24'hF80002
`define PDC_ADDR_CFG_BOR 24'hF80004
`define PDC_ADDR_CFG_PROT 24'hF8000A
`define PDC_RST_DIS 16'h0000
`define PDC_RST_CFG 16'hFFFF
`define PDC_CFG_DATA_W 16
`define PDC_DBG_RAM_BYTES 16'h0050
`define PDC_DIS_LAT_CYC 1
`define PDC_PAIR_PRIMARY 2'h0
`define PDC_BIT_TIMER5 15
`define PDC_BIT_TIMER1 11
`define PDC_BIT_CODEC 8
`define PDC_BIT_I2C 7
`define PDC_BIT_UART2 6
`define PDC_BIT_UART1 5
`define PDC_BIT_SPI2 4
`define PDC_BIT_SPI1 3
`define PDC_BIT_CAN2 2
`define PDC_BIT_CAN1 1
`define PDC_BIT_ADC 0
`endif

//--- pdc_top.v
// Peripheral disable registers, configuration word store and debug resource steering
`include "pdc_consts.vh"
module pdc_top #(
    parameter [15:0] IMPL1 = 16'hF9FF,      // Peripherals present in this variant, register one
    parameter [15:0] IMPL2 = 16'hFFFF       // Peripherals present in this variant, register two
) (
    input wire i_clk,                       // Instruction-cycle clock
    input wire i_nrst,                      // Asynchronous reset, active low
    input wire i_ce,                        // Clock enable, freezes state when low
    input wire [15:0] i_sfr_addr,           // Data-space register address
    input wire i_sfr_wr,                    // Register write strobe
    input wire i_sfr_rd,                    // Register read strobe
    input wire [15:0] i_sfr_wdata,          // Register write data
    output reg [15:0] o_sfr_rdata,          // Register read data, one cycle after read
    output reg o_sfr_hit,                   // Read hit one of the disable registers
    input wire i_prog_mode,                 // Programmer holds the configuration port
    input wire i_prog_wr,                   // Programmer write strobe
    input wire [1:0] i_prog_sel,            // Configuration word select
    input wire [15:0] i_prog_data,          // Programmer write data
    input wire i_tbl_rd,                    // Table read strobe
    input wire [23:0] i_tbl_addr,           // Table read program-space address
    output reg [23:0] o_tbl_data,           // Table read data
    output reg o_tbl_hit,                   // Table read hit a configuration word
    output wire [15:0] o_cfg_osc,           // Oscillator configuration word
    output wire [15:0] o_cfg_wdt,           // Watchdog configuration word
    output wire [15:0] o_cfg_bor,           // Brown-out and power-on configuration word
    output wire [15:0] o_cfg_prot,          // Code protect configuration word
    input wire [31:0] i_periph_clk,         // Free-running clock for each peripheral
    output wire [31:0] o_periph_clk,        // Gated clock for each peripheral
    output wire [31:0] o_periph_en,         // Peripheral enabled
    output wire [31:0] o_periph_wr_en,      // Peripheral register writes allowed
    input wire i_dbg_en,                    // In-circuit debugging enabled
    input wire [1:0] i_dbg_pair,            // Selected debug pin pair
    output wire [15:0] o_dbg_ram_limit,     // First data RAM byte left to the application
    output wire [3:0] o_dbg_pair_own,       // One-hot pair taken by the debugger
    output wire o_dbg_shares_prog,          // Debug pair uses the programming pins
    input wire [3:0] i_dbg_clk_pin,         // Debug clock pins, one per pair
    input wire [3:0] i_dbg_data_pin,        // Debug data pins in, one per pair
    output wire [3:0] o_dbg_data_pin,       // Debug data pins out
    output wire [3:0] o_dbg_data_oe,        // Debug data pins output enable
    input wire i_dbg_data_out,              // Debug engine data to drive
    input wire i_dbg_data_drive,            // Debug engine wants to drive data
    output wire o_dbg_clk,                  // Synchronised selected debug clock
    output wire o_dbg_data                  // Synchronised selected debug data
);
    reg [15:0] dis1_r;
    reg [15:0] dis2_r;
    reg [31:0] en_r;
    reg [15:0] cfg_r [0:3];
    reg [3:0] clk_s1_r;
    reg [3:0] clk_s2_r;
    reg [3:0] dat_s1_r;
    reg [3:0] dat_s2_r;
    reg [23:0] tbl_nxt;
    reg tbl_hit_nxt;
    wire [31:0] impl = {IMPL1, IMPL2};
    wire [31:0] dis_all = {dis1_r, dis2_r};
    wire sel1 = i_sfr_addr == `PDC_ADDR_DIS1;
    wire sel2 = i_sfr_addr == `PDC_ADDR_DIS2;

    // Disable registers; bit layout follows peripheral order
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dis1_r <= `PDC_RST_DIS;
            dis2_r <= `PDC_RST_DIS;
            o_sfr_rdata <= 16'h0000;
            o_sfr_hit <= 1'b0;
        end else if (i_ce) begin
            if (i_sfr_wr && sel1) begin
                dis1_r <= i_sfr_wdata;
            end
            if (i_sfr_wr && sel2) begin
                dis2_r <= i_sfr_wdata;
            end
            o_sfr_hit <= i_sfr_rd && (sel1 || sel2);
            if (i_sfr_rd && sel1) begin
                o_sfr_rdata <= dis1_r;
            end else if (i_sfr_rd && sel2) begin
                o_sfr_rdata <= dis2_r;
            end else begin
                o_sfr_rdata <= 16'h0000;
            end
        end
    end

    // Enable follows the register one cycle late
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            en_r <= 32'h00000000;
        end else if (i_ce) begin
            en_r <= ~dis_all & impl;
        end
    end
    assign o_periph_en = en_r;
    // Registers of an off peripheral ignore writes
    assign o_periph_wr_en = en_r;

    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : gclk
            reg lat_r;
            // Gate moves only on the falling edge, so a high phase is never cut short
            always @(negedge i_periph_clk[g] or negedge i_nrst) begin
                if (!i_nrst) begin
                    lat_r <= 1'b0;
                end else begin
                    lat_r <= en_r[g];
                end
            end
            // All clocks to the peripheral stop while off
            assign o_periph_clk[g] = i_periph_clk[g] & lat_r;
        end
    endgenerate

    // Configuration words: written by the programmer only
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_r[0] <= `PDC_RST_CFG;
            cfg_r[1] <= `PDC_RST_CFG;
            cfg_r[2] <= `PDC_RST_CFG;
            cfg_r[3] <= `PDC_RST_CFG;
        end else if (i_ce && i_prog_mode && i_prog_wr) begin
            cfg_r[i_prog_sel] <= i_prog_data;
        end
    end
    assign o_cfg_osc = cfg_r[0];
    assign o_cfg_wdt = cfg_r[1];
    assign o_cfg_bor = cfg_r[2];
    assign o_cfg_prot = cfg_r[3];

    // Table read decode; upper byte reads as zero
    always @* begin
        tbl_nxt = 24'h000000;
        tbl_hit_nxt = 1'b1;
        case (i_tbl_addr)
            `PDC_ADDR_CFG_OSC: tbl_nxt = {8'h00, cfg_r[0]};
            `PDC_ADDR_CFG_WDT: tbl_nxt = {8'h00, cfg_r[1]};
            `PDC_ADDR_CFG_BOR: tbl_nxt = {8'h00, cfg_r[2]};
            `PDC_ADDR_CFG_PROT: tbl_nxt = {8'h00, cfg_r[3]};
            default: tbl_hit_nxt = 1'b0;
        endcase
    end
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tbl_data <= 24'h000000;
            o_tbl_hit <= 1'b0;
        end else if (i_ce) begin
            o_tbl_hit <= i_tbl_rd && tbl_hit_nxt;
            o_tbl_data <= i_tbl_rd ? tbl_nxt : 24'h000000;
        end
    end

    // Debug resources
    assign o_dbg_ram_limit = i_dbg_en ? `PDC_DBG_RAM_BYTES : 16'h0000;
    assign o_dbg_pair_own = i_dbg_en ? (4'h1 << i_dbg_pair) : 4'h0;
    // Primary pair rides on the programming pins
    assign o_dbg_shares_prog = i_dbg_en && (i_dbg_pair == `PDC_PAIR_PRIMARY);
    // Data pin is two-way, clock pin input only
    assign o_dbg_data_pin = {4{i_dbg_data_out}};
    assign o_dbg_data_oe = (i_dbg_data_drive ? 4'hF : 4'h0) & o_dbg_pair_own;

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            clk_s1_r <= 4'h0;
            clk_s2_r <= 4'h0;
            dat_s1_r <= 4'h0;
            dat_s2_r <= 4'h0;
        end else if (i_ce) begin
            clk_s1_r <= i_dbg_clk_pin;
            clk_s2_r <= clk_s1_r;
            dat_s1_r <= i_dbg_data_pin;
            dat_s2_r <= dat_s1_r;
        end
    end
    assign o_dbg_clk = i_dbg_en & clk_s2_r[i_dbg_pair];
    assign o_dbg_data = i_dbg_en & dat_s2_r[i_dbg_pair];
endmodule

//--- pdc_checker.sv
// Concurrent checks on disable registers, table reads and debug steering
module pdc_checker #(
    parameter IMPL1 = 16'hF9FF, // Implemented peripherals, register one
    parameter IMPL2 = 16'hFFFF // Implemented peripherals, register two
) (
    input wire i_clk, input wire i_nrst, input wire i_ce,
    input wire [15:0] i_sfr_addr, input wire i_sfr_wr, input wire i_sfr_rd,
    input wire [15:0] i_sfr_wdata, input wire [15:0] o_sfr_rdata, input wire o_sfr_hit,
    input wire [23:0] o_tbl_data, input wire o_tbl_hit,
    input wire [31:0] o_periph_en, input wire [31:0] o_periph_wr_en,
    input wire i_dbg_en, input wire [1:0] i_dbg_pair, input wire [15:0] o_dbg_ram_limit,
    input wire [3:0] o_dbg_pair_own, input wire o_dbg_shares_prog
);
    localparam logic [15:0] M1 = IMPL1;
    localparam logic [15:0] M2 = IMPL2;
    wire wr1 = i_ce && i_sfr_wr && i_sfr_addr == 16'h0770;
    wire wr2 = i_ce && i_sfr_wr && i_sfr_addr == 16'h0772;
    wire hit = i_sfr_addr == 16'h0770 || i_sfr_addr == 16'h0772;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    chk_tbl_upper: assert property (o_tbl_hit |-> o_tbl_data[23:16] == 8'h00)
        else $error("table read upper byte not zero");
    chk_dis1_delay: assert property (wr1 ##1 i_ce |=>
        o_periph_en[31:16] == (~$past(i_sfr_wdata, 2) & M1)) else $error("register one lag");
    chk_dis2_delay: assert property (wr2 ##1 i_ce |=>
        o_periph_en[15:0] == (~$past(i_sfr_wdata, 2) & M2)) else $error("register two lag");
    chk_wr_block: assert property (o_periph_wr_en == o_periph_en)
        else $error("write enable differs from enable");
    chk_rd_hit: assert property (i_ce && i_sfr_rd && hit |=> o_sfr_hit)
        else $error("register read not answered");
    chk_rd_miss: assert property (i_ce && i_sfr_rd && !hit |=> !o_sfr_hit && o_sfr_rdata == 0)
        else $error("unmapped read answered");
    chk_dbg_ram: assert property (o_dbg_ram_limit == (i_dbg_en ? 16'h0050 : 16'h0000))
        else $error("debug RAM limit wrong");
    chk_pair_own: assert property (o_dbg_pair_own == (i_dbg_en ? 4'h1 << i_dbg_pair : 4'h0))
        else $error("debug pair owner wrong");
    chk_shares_prog: assert property (o_dbg_shares_prog == (i_dbg_en && i_dbg_pair == 2'h0))
        else $error("shared programming pins wrong");
endmodule
bind pdc_top pdc_checker #(.IMPL1(IMPL1), .IMPL2(IMPL2)) chk_u (.*);

//--- pdc_prog_model.sv
// Device programmer model that loads the configuration words
module pdc_prog_model (
    input wire logic i_clk, // Instruction clock
    output logic o_prog_mode = 1'h0, // Holds the configuration port
    output logic o_prog_wr = 1'h0, // Write strobe
    output logic [1:0] o_prog_sel = 2'h0, // Word select
    output logic [15:0] o_prog_data = 16'h0000 // Word contents
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic load(input logic [1:0] s, input logic [15:0] d);
        @(negedge i_clk);
        {o_prog_mode, o_prog_wr, o_prog_sel, o_prog_data} = {2'h3, s, d};
        @(negedge i_clk);
        // Released data lines must not look like the last word
        {o_prog_mode, o_prog_wr, o_prog_data} = {2'h0, ~d};
    endtask
endmodule

//--- tb.sv
// Self-checking bench for the peripheral disable and configuration block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = '0, i_nrst = '0, i_sfr_wr = '0, i_sfr_rd = '0, i_tbl_rd = '0, i_dbg_en = '0;
    logic [15:0] i_sfr_addr = '0, i_sfr_wdata = '0, o_sfr_rdata, o_dbg_ram_limit, p_data, d, a;
    logic [15:0] r1 = '0, r2 = '0, cfg[4], o_cfg_osc, o_cfg_wdt, o_cfg_bor, o_cfg_prot;
    logic [23:0] i_tbl_addr = '0, o_tbl_data, exp_q[$];
    logic [1:0] i_dbg_pair = '0, p_sel;
    logic [3:0] i_dbg_clk_pin = '0, i_dbg_data_pin = '0, o_dbg_pair_own, o_dbg_data_pin, o_dbg_data_oe;
    logic o_sfr_hit, o_tbl_hit, p_mode, p_wr, dbg_out = '0, o_dbg_shares_prog, o_dbg_clk, o_dbg_data;
    logic [31:0] seed = 32'h126D, o_periph_clk, o_periph_en, o_periph_wr_en;
    logic i_ce = '1;
    logic [7:0] pin_old = '0;
    int n_errors = 0, check_count = 0;
    always #10 i_clk = ~i_clk;
    pdc_top dut_u (.*, .i_prog_mode(p_mode), .i_prog_wr(p_wr), .i_prog_sel(p_sel),
        .i_prog_data(p_data), .i_periph_clk({32{i_clk}}), .i_dbg_data_out(dbg_out),
        .i_dbg_data_drive(dbg_out));
    pdc_prog_model prog_u (.i_clk(i_clk), .o_prog_mode(p_mode), .o_prog_wr(p_wr),
        .o_prog_sel(p_sel), .o_prog_data(p_data));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // For a read, dv is the value the register should return
    task automatic sfr(input logic w, input logic [15:0] ad, input logic [15:0] dv);
        @(negedge i_clk);
        {i_sfr_addr, i_sfr_wdata, i_sfr_wr, i_sfr_rd} = {ad, dv, w, !w};
        if (!w && (ad == 16'h0770 || ad == 16'h0772)) exp_q.push_back({8'h00, dv});
        @(negedge i_clk);
        {i_sfr_wr, i_sfr_rd} = 2'h0;
    endtask
    task automatic tbl(input logic [1:0] s);
        @(negedge i_clk);
        i_tbl_addr = {20'hF8000, (s == 2'h3) ? 4'hA : {1'h0, s, 1'h0}};
        i_tbl_rd = 1'h1;
        exp_q.push_back({8'h00, cfg[s]});
        @(negedge i_clk);
        i_tbl_rd = 1'h0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(negedge i_clk) begin
        {i_dbg_clk_pin, i_dbg_data_pin, dbg_out} = 9'(rnd());
        if (o_sfr_hit === 1'h1) check(o_sfr_rdata, exp_q.pop_front());
        if (o_tbl_hit === 1'h1) check(o_tbl_data, exp_q.pop_front());
    end
    // Synchronised pins lag two enabled edges, so the history only moves on enabled edges
    always @(posedge i_clk) begin
        #1;
        if (!i_nrst) begin
            pin_old = '0;
        end else if (i_ce) begin
            check(o_dbg_clk, i_dbg_en & pin_old[4 + i_dbg_pair]);
            check(o_dbg_data, i_dbg_en & pin_old[i_dbg_pair]);
            check(o_dbg_data_oe, {4{dbg_out}} & (i_dbg_en ? 4'h1 << i_dbg_pair : 4'h0));
            check(o_dbg_data_pin, {4{dbg_out}});
            pin_old = {i_dbg_clk_pin, i_dbg_data_pin};
        end
    end
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        @(negedge i_clk) i_nrst = 1'h1;
        sfr(1'h0, 16'h0770, 16'h0000);
        sfr(1'h0, 16'h0772, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            cfg[i] = 16'(rnd());
            prog_u.load(2'(i), cfg[i]);
        end
        check(o_cfg_osc, cfg[0]);
        check(o_cfg_wdt, cfg[1]);
        check(o_cfg_bor, cfg[2]);
        check(o_cfg_prot, cfg[3]);
        for (int i = 0; i < 4; i++) tbl(2'(i));
        for (int i = 0; i < 40; i++) begin
            d = 16'(rnd()) & 16'hF9FF;
            a = i[0] ? 16'h0772 : 16'h0770;
            sfr(1'h1, a, d);
            sfr(1'h0, a, d);
            sfr(1'h0, 16'h0774, 16'h0000);
            if (a[1]) r2 = d; else r1 = d;
            @(posedge i_clk) #1;
            check(o_periph_clk, ~{r1, r2} & 32'hF9FFFFFF);
            check(o_periph_wr_en, ~{r1, r2} & 32'hF9FFFFFF);
        end
        // A write while the clock enable is low must leave the register untouched
        @(negedge i_clk) i_ce = 1'h0;
        sfr(1'h1, 16'h0770, ~r1);
        @(negedge i_clk) i_ce = 1'h1;
        sfr(1'h0, 16'h0770, r1);
        for (int i = 0; i < 8; i++) begin
            @(negedge i_clk) {i_dbg_en, i_dbg_pair} = 3'(i);
            @(negedge i_clk) check(o_dbg_pair_own, i[2] ? 4'h1 << i[1:0] : 4'h0);
        end
        @(negedge i_clk) i_nrst = 1'h0;
        @(negedge i_clk) i_nrst = 1'h1;
        sfr(1'h0, 16'h0770, 16'h0000);
        check(o_periph_en, 32'hF9FFFFFF);
        repeat (2) @(negedge i_clk);
        end_of_test();
    end
endmodule
